// ---- logic/psu_dev_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "psu_link_map.svh"
module psu_dev_end #(
  parameter int STRETCH_CYC = `STRETCH_MAX_NS / `CLK_PERIOD_NS,
  parameter int TIMEOUT_CYC = `SCL_LOW_TIMEOUT_NS / `CLK_PERIOD_NS + 1
) (
  input  wire logic  clk,
  input  wire logic  reset,
  psu_link_if.device link,
  input  wire logic  addr_select_bit2,
  input  wire logic  addr_select_bit1,
  input  wire logic  addr_select_bit0,
  input  wire logic  shutdown_event,
  input  wire logic  warning_event,
  input  wire logic  ctl_rd_valid,
  input  wire logic  [7:0] ctl_rd_data,
  output logic       [7:0] ctl_cmd,
  output logic       ctl_wr_valid,
  output logic       [7:0] ctl_wr_data,
  output logic       [7:0] ctl_wr_index,
  output logic       ctl_wr_end,
  output logic       ctl_rd_req,
  output logic       [7:0] ctl_rd_index,
  output logic       wp_active
);
  localparam logic [15:0] STR_LAST = 16'(STRETCH_CYC - 1);
  localparam logic [20:0] TO_LAST  = 21'(TIMEOUT_CYC);
  localparam logic [7:0]  FILL     = `FILL_BYTE;

  psu_link_pkg::dev_s q;
  psu_link_pkg::dev_s d;
  logic [7:0] mem [0:`EEP_SIZE-1];
  logic [7:0] eep_rd_q;
  logic       mem_we;
  logic       ack;
  logic       load;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_p;
  logic       stop_p;
  logic [7:0] eep_addr;

  function automatic logic addr_match(input logic [7:0] b,
                                      input logic [7:0] a);
    addr_match = (b[7:1] == a[7:1]);
  endfunction

  // pins sampled far faster than the 100 kHz bus
  line_sync u_sync (
    .clk      (clk),
    .reset    (reset),
    .scl_i    (link.scl),
    .sda_i    (link.sda),
    .scl      (scl),
    .sda      (sda),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start_p  (start_p),
    .stop_p   (stop_p)
  );

  // memory address tracks the controller address
  assign eep_addr = q.ctl_addr - `EEP_CTL_OFFSET;

  // protocol engine
  always_comb begin
    d = q;
    mem_we = 1'b0;
    ack = 1'b0;
    load = 1'b0;
    d.wr_valid = 1'b0;
    d.wr_end = 1'b0;
    d.rd_req = 1'b0;
    d.sel_m = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
    d.sel = q.sel_m;
    d.ctl_addr = `CTL_ADDR_BASE + {4'h0, q.sel, 1'b0};
    d.alert_oe = shutdown_event | warning_event;
    if (scl || q.state == psu_link_pkg::DS_IDLE) begin
      d.low_cnt = '0;
    end else begin
      d.low_cnt = q.low_cnt + 21'd1;
    end
    if (stop_p) begin
      d.state = psu_link_pkg::DS_IDLE;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
      d.stretch = 1'b0;
      // command-only, byte and word writes all end here
      // an idle engine holds stale counts, so a stray stop must not end one
      d.wr_end = ~q.to_eep & ~q.rw & (q.bytecnt >= 9'd2) &
                 (q.state != psu_link_pkg::DS_IDLE);
    end else if (start_p) begin
      d.state = psu_link_pkg::DS_RX;
      d.bitcnt = '0;
      d.bytecnt = '0;
      d.rd_index = '0;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
      d.stretch = 1'b0;
    end else if (q.low_cnt == TO_LAST) begin
      d.state = psu_link_pkg::DS_IDLE;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
      d.stretch = 1'b0;
    end else begin
      unique case (q.state)
        psu_link_pkg::DS_IDLE: begin
          // nothing driven until addressed
          d.sda_oe = 1'b0;
        end
        psu_link_pkg::DS_RX: begin
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], sda};
            d.bitcnt = q.bitcnt + 4'd1;
          end else if (scl_fall && q.bitcnt == 4'd8) begin
            ack = 1'b1;
            if (q.bytecnt == 9'd0) begin
              d.rw = q.shreg[0];
              d.to_eep = addr_match(q.shreg, eep_addr);
              ack = addr_match(q.shreg, eep_addr) |
                    addr_match(q.shreg, q.ctl_addr);
            end else if (q.to_eep) begin
              if (q.bytecnt == 9'd1) begin
                d.ptr[14:8] = q.shreg[6:0];
              end else if (q.bytecnt == 9'd2) begin
                d.ptr[7:0] = q.shreg;
              end else begin
                mem_we = ~q.wp;
                d.ptr[4:0] = q.ptr[4:0] + 5'd1;
              end
            end else if (q.bytecnt == 9'd1) begin
              d.cmd = q.shreg;
            end else if (q.bytecnt <= 9'd256) begin
              d.wr_valid = 1'b1;
              d.wr_data = q.shreg;
              d.wr_index = 8'(q.bytecnt - 9'd2);
              if (q.bytecnt == 9'd2 && q.cmd == `WP_CMD) begin
                d.wp = (q.shreg != 8'h00);
              end
            end else begin
              ack = 1'b0;
            end
            if (q.bytecnt != 9'h1ff) begin
              d.bytecnt = q.bytecnt + 9'd1;
            end
            d.state = ack ? psu_link_pkg::DS_ACK : psu_link_pkg::DS_IDLE;
            d.sda_oe = ack;
          end
        end
        psu_link_pkg::DS_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = '0;
            if (q.rw) begin
              load = 1'b1;
            end else begin
              d.state = psu_link_pkg::DS_RX;
            end
          end
        end
        psu_link_pkg::DS_TX: begin
          if (q.stretch) begin
            d.str_cnt = q.str_cnt + 16'd1;
            if (ctl_rd_valid || q.str_cnt == STR_LAST) begin
              d.stretch = 1'b0;
              d.shreg = ctl_rd_valid ? ctl_rd_data : FILL;
              d.sda_oe = ctl_rd_valid ? ~ctl_rd_data[7] : ~FILL[7];
              d.rd_index = q.rd_index + 8'd1;
            end
          end else if (q.scl_oe) begin
            // data settles a cycle before the clock is let go
            d.scl_oe = 1'b0;
          end else if (scl_fall) begin
            if (q.bitcnt == 4'd7) begin
              d.sda_oe = 1'b0;
              d.state = psu_link_pkg::DS_MACK;
            end else begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.sda_oe = ~q.shreg[6];
              d.bitcnt = q.bitcnt + 4'd1;
            end
          end
        end
        psu_link_pkg::DS_MACK: begin
          // a nack ends a byte or word read
          if (scl_rise && sda) begin
            d.state = psu_link_pkg::DS_IDLE;
          end else if (scl_fall) begin
            load = 1'b1;
          end
        end
      endcase
    end
    // fetch the next byte to send
    if (load) begin
      d.state = psu_link_pkg::DS_TX;
      d.bitcnt = '0;
      if (q.to_eep) begin
        d.shreg = eep_rd_q;
        d.sda_oe = ~eep_rd_q[7];
        d.ptr = q.ptr + 15'd1;
      end else if (q.rd_index == `BLOCK_MAX) begin
        d.shreg = FILL;
        d.sda_oe = ~FILL[7];
      end else begin
        d.rd_req = 1'b1;
        d.stretch = 1'b1;
        d.scl_oe = 1'b1;
        d.str_cnt = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.state <= psu_link_pkg::DS_IDLE;
      q.ctl_addr <= `CTL_ADDR_BASE;
      q.wp <= `WP_RESET;
    end else begin
      q <= d;
    end
  end

  // user memory, never touched by supply logic
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[q.ptr] <= q.shreg;
    end
    eep_rd_q <= mem[q.ptr];
  end

  // open-drain pins only ever pull low
  assign link.dev_scl_o   = 1'b0;
  assign link.dev_sda_o   = 1'b0;
  assign link.dev_alert_o = 1'b0;
  assign link.dev_scl_oe  = q.scl_oe;
  assign link.dev_sda_oe  = q.sda_oe;
  assign link.dev_alert_oe = q.alert_oe;
  assign ctl_cmd      = q.cmd;
  assign ctl_wr_valid = q.wr_valid;
  assign ctl_wr_data  = q.wr_data;
  assign ctl_wr_index = q.wr_index;
  assign ctl_wr_end   = q.wr_end;
  assign ctl_rd_req   = q.rd_req;
  assign ctl_rd_index = q.rd_index;
  assign wp_active    = q.wp;
endmodule
`default_nettype wire

// ---- logic/psu_link_map.svh ----
`ifndef PSU_LINK_MAP_SVH
`define PSU_LINK_MAP_SVH
// clock and bus timing
`define CLK_PERIOD_NS      20
`define STRETCH_MAX_NS     1000000
`define SCL_LOW_TIMEOUT_NS 25000000
`define SCL_QUARTER_NS     2500
// bus addresses, 8-bit form with the read/write bit clear
`define EEP_ADDR_BASE  8'ha0
`define CTL_ADDR_BASE  8'hb0
`define EEP_CTL_OFFSET 8'h10
// storage and transfer sizes
`define EEP_SIZE       32768
`define BLOCK_MAX      8'hff
`define FILL_BYTE      8'hff
// write protect command and its reset state
`define WP_CMD         8'h10
`define WP_RESET       1'b1
`endif

// ---- logic/psu_link_pkg.sv ----
package psu_link_pkg;
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_RX   = 5'h02,
    DS_ACK  = 5'h04,
    DS_TX   = 5'h08,
    DS_MACK = 5'h10
  } dev_state_e;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_BYTE  = 4'h4,
    HS_STOP  = 4'h8
  } host_state_e;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } host_op_e;

  typedef struct packed {
    logic scl_m;
    logic sda_m;
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
  } sync_s;

  typedef struct packed {
    dev_state_e  state;
    logic [2:0]  sel_m;
    logic [2:0]  sel;
    logic [7:0]  ctl_addr;
    logic [7:0]  shreg;
    logic [3:0]  bitcnt;
    logic [8:0]  bytecnt;
    logic        rw;
    logic        to_eep;
    logic        wp;
    logic [14:0] ptr;
    logic [7:0]  cmd;
    logic        sda_oe;
    logic        scl_oe;
    logic        stretch;
    logic [15:0] str_cnt;
    logic [20:0] low_cnt;
    logic        alert_oe;
    logic        wr_valid;
    logic [7:0]  wr_data;
    logic [7:0]  wr_index;
    logic        wr_end;
    logic        rd_req;
    logic [7:0]  rd_index;
  } dev_s;

  typedef struct packed {
    host_state_e state;
    logic [7:0]  cnt;
    logic [1:0]  qt;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    host_op_e    op;
    logic        last;
    logic        sda_oe;
    logic        scl_oe;
    logic        ready;
    logic        done;
    logic [7:0]  rdata;
    logic        nack;
    logic        alert_m;
    logic        alert;
  } host_s;
endpackage

// ---- logic/psu_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface psu_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_alert_o;
  logic dev_alert_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;
  logic fault_alert_n;

  // wired-and of open-drain drivers over pull-ups
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));
  assign fault_alert_n = ~(dev_alert_oe & ~dev_alert_o);

  modport device (
    input  scl, sda,
    output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
    output dev_alert_o, dev_alert_oe
  );
  modport host (
    input  scl, sda, fault_alert_n,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
  );
endinterface
`default_nettype wire

// ---- logic/line_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl,
  output logic      sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_p,
  output logic      stop_p
);
  psu_link_pkg::sync_s q;
  psu_link_pkg::sync_s d;

  // two stages, then one more for edge finding
  always_comb begin
    d = q;
    d.scl_m = scl_i;
    d.sda_m = sda_i;
    d.scl_s = q.scl_m;
    d.sda_s = q.sda_m;
    d.scl_p = q.scl_s;
    d.sda_p = q.sda_s;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  // edges and bus conditions from settled samples only
  assign scl      = q.scl_s;
  assign sda      = q.sda_s;
  assign scl_rise = q.scl_s & ~q.scl_p;
  assign scl_fall = ~q.scl_s & q.scl_p;
  assign start_p  = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_p   = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
endmodule
`default_nettype wire

// ---- logic/psu_host_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "psu_link_map.svh"
module psu_host_end (
  input  wire logic             clk,
  input  wire logic             reset,
  psu_link_if.host              link,
  input  wire logic             op_valid,
  input  wire psu_link_pkg::host_op_e op_code,
  input  wire logic       [7:0] op_wdata,
  input  wire logic             op_last,
  output logic                  op_ready,
  output logic                  op_done,
  output logic            [7:0] op_rdata,
  output logic                  op_nack,
  output logic                  alert_active
);
  localparam logic [7:0] QTR_LAST = 8'(`SCL_QUARTER_NS / `CLK_PERIOD_NS - 1);

  psu_link_pkg::host_s q;
  psu_link_pkg::host_s d;
  logic scl;
  logic sda;
  logic adv;
  logic tick;
  logic is_wr;

  line_sync u_sync (
    .clk      (clk),
    .reset    (reset),
    .scl_i    (link.scl),
    .sda_i    (link.sda),
    .scl      (scl),
    .sda      (sda),
    .scl_rise (),
    .scl_fall (),
    .start_p  (),
    .stop_p   ()
  );

  // quarter-period timer; it waits while the target stretches the clock
  assign adv   = (q.state != psu_link_pkg::HS_IDLE) & ~(q.qt == 2'd1 & ~scl);
  assign tick  = adv & (q.cnt == QTR_LAST);
  assign is_wr = (q.op == psu_link_pkg::OP_WRITE);

  // byte-level bus controller
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.alert_m = link.fault_alert_n;
    d.alert = ~q.alert_m;
    if (adv) begin
      d.cnt = tick ? 8'h00 : q.cnt + 8'h01;
    end
    if (tick) begin
      d.qt = q.qt + 2'd1;
    end
    unique case (q.state)
      psu_link_pkg::HS_IDLE: begin
        if (op_valid) begin
          // one op per byte keeps single-byte accesses simple
          d.ready = 1'b0;
          d.op = op_code;
          d.shreg = op_wdata;
          d.last = op_last;
          d.qt = 2'd0;
          d.cnt = 8'h00;
          d.bitn = 4'd0;
          d.nack = 1'b0;
          unique case (op_code)
            psu_link_pkg::OP_START: begin
              d.state = psu_link_pkg::HS_START;
              d.sda_oe = 1'b0;
            end
            psu_link_pkg::OP_STOP: begin
              d.state = psu_link_pkg::HS_STOP;
              d.sda_oe = 1'b1;
            end
            psu_link_pkg::OP_WRITE: begin
              // bytes go out in issue order, address high byte first
              d.state = psu_link_pkg::HS_BYTE;
              d.sda_oe = ~op_wdata[7];
            end
            psu_link_pkg::OP_READ: begin
              d.state = psu_link_pkg::HS_BYTE;
              d.sda_oe = 1'b0;
            end
          endcase
        end
      end
      psu_link_pkg::HS_START: begin
        if (tick) begin
          unique case (q.qt)
            2'd0: d.scl_oe = 1'b0;
            2'd1: d.sda_oe = 1'b1;
            // one more quarter keeps the first clock low long enough
            2'd2: d.scl_oe = 1'b1;
            default: begin
              d.state = psu_link_pkg::HS_IDLE;
              d.ready = 1'b1;
              d.done = 1'b1;
            end
          endcase
        end
      end
      psu_link_pkg::HS_STOP: begin
        if (tick) begin
          unique case (q.qt)
            2'd0: d.scl_oe = 1'b0;
            2'd1: d.sda_oe = 1'b0;
            default: begin
              d.state = psu_link_pkg::HS_IDLE;
              d.ready = 1'b1;
              d.done = 1'b1;
            end
          endcase
        end
      end
      psu_link_pkg::HS_BYTE: begin
        if (tick) begin
          unique case (q.qt)
            2'd0: d.scl_oe = 1'b0;
            2'd1: d.scl_oe = 1'b0;
            2'd2: begin
              if (q.bitn < 4'd8) begin
                d.shreg = {q.shreg[6:0], sda};
              end else begin
                d.nack = sda;
              end
              d.scl_oe = 1'b1;
            end
            2'd3: begin
              if (q.bitn == 4'd8) begin
                d.state = psu_link_pkg::HS_IDLE;
                d.ready = 1'b1;
                d.done = 1'b1;
                d.rdata = q.shreg;
              end else begin
                d.bitn = q.bitn + 4'd1;
                if (q.bitn == 4'd7) begin
                  d.sda_oe = ~is_wr & ~q.last;
                end else begin
                  d.sda_oe = is_wr & ~q.shreg[7];
                end
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.state <= psu_link_pkg::HS_IDLE;
      q.op <= psu_link_pkg::OP_START;
      q.ready <= 1'b1;
      q.alert_m <= 1'b1; // pin idles high, so no false alert after reset
    end else begin
      q <= d;
    end
  end

  // protect must be lifted by a command before memory writes
  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = q.scl_oe;
  assign link.host_sda_oe = q.sda_oe;
  assign op_ready     = q.ready;
  assign op_done      = q.done;
  assign op_rdata     = q.rdata;
  assign op_nack      = q.nack;
  assign alert_active = q.alert;
endmodule
`default_nettype wire

// ---- tb/psu_link_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module psu_link_assertions #(
  parameter int STRETCH_CYC = 50000,
  parameter int TIMEOUT_CYC = 1250001
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic fault_alert_n,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic dev_alert_oe,
  input wire logic shutdown_event,
  input wire logic warning_event
);
  typedef struct packed {
    logic [20:0] str;
    logic [20:0] low;
    logic [9:0]  per;
    logic        scl_q;
  } cnt_s;
  cnt_s cnt_q;
  cnt_s cnt_d;

  // stretch length, clock low time and fall-to-fall period
  always_comb begin
    cnt_d = cnt_q;
    cnt_d.str = dev_scl_oe ? cnt_q.str + 21'h1 : 21'h0;
    cnt_d.low = scl ? 21'h0 : cnt_q.low + {20'h0, ~&cnt_q.low};
    cnt_d.per = cnt_q.per + {9'h0, ~&cnt_q.per};
    if (cnt_q.scl_q && !scl) begin
      cnt_d.per = 10'h0;
    end
    cnt_d.scl_q = scl;
  end

  // period starts saturated so the first fall after reset passes
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '{str: 21'h0, low: 21'h0, per: 10'h3ff, scl_q: 1'b1};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_target_no_start:
    assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data drive moved while clock high");
  a_stretch_bounded:
    assert property (int'(cnt_q.str) <= STRETCH_CYC + 4)
    else $error("clock stretch held too long");
  a_timeout_idle:
    assert property (int'(cnt_q.low) > TIMEOUT_CYC + 8 |->
                     !dev_sda_oe && !dev_scl_oe)
    else $error("device still drives after clock low time-out");
  a_clock_period_min:
    assert property ($fell(scl) |-> cnt_q.per >= 10'h1ea)
    else $error("clock period shorter than allowed");
  a_clock_low_min:
    assert property ($rose(scl) |-> cnt_q.low >= 21'heb)
    else $error("clock low phase shorter than allowed");
  a_alert_raised:
    assert property ((shutdown_event || warning_event) [*2] |-> dev_alert_oe)
    else $error("alert not driven while an event is present");
  a_alert_released:
    assert property (!(shutdown_event || warning_event) [*2] |-> fault_alert_n)
    else $error("alert pin low without an event");
  a_stop_releases:
    assert property ($rose(sda) && scl |-> !dev_sda_oe [*8])
    else $error("device drives data line right after stop");
  a_stretch_low_only:
    assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("device pulled a high clock line low");
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] addr;
    logic       nack;
    logic       sd;
    logic       wr;
  } row_s;
  localparam logic [7:0] CTL = 8'hba;
  localparam logic [7:0] EEP = 8'haa;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] sel = 3'h0;
  logic       shutdown_event = 1'b0;
  logic       warning_event = 1'b0;
  logic       ctl_rd_valid = 1'b0;
  logic [7:0] rd_wait = 8'h00;
  logic       wr_end_seen = 1'b0;
  logic [7:0] wr_pulses = 8'h00;
  logic       ctl_wr_valid;
  logic [7:0] ctl_rd_index;
  logic       op_valid = 1'b0;
  psu_link_pkg::host_op_e op_code = psu_link_pkg::OP_START;
  logic [7:0] op_wdata = 8'h00;
  logic       op_last = 1'b0;
  logic [7:0] ctl_cmd;
  logic [7:0] ctl_wr_data;
  logic [7:0] ctl_wr_index;
  logic [7:0] op_rdata;
  logic       ctl_wr_end;
  logic       ctl_rd_req;
  logic       wp_active;
  logic       op_ready;
  logic       op_done;
  logic       op_nack;
  logic       alert_active;
  int         n_fail = 0;
  int         comparisons = 0;
  row_s       rows [3] = '{'{3'h0, 8'hb0, 1'b0, 1'b0, 1'b0},
                           '{3'h7, 8'hae, 1'b0, 1'b1, 1'b0},
                           '{3'h5, 8'hb8, 1'b1, 1'b0, 1'b1}};

  always #10 clk = ~clk;

  psu_link_if i_psu_link_if ();

  // device end and host end facing each other over one link
  psu_dev_end #(.STRETCH_CYC(200), .TIMEOUT_CYC(1000)) i_psu_dev_end (
    .clk(clk), .reset(reset), .link(i_psu_link_if.device),
    .addr_select_bit2(sel[2]), .addr_select_bit1(sel[1]),
    .addr_select_bit0(sel[0]), .shutdown_event(shutdown_event),
    .warning_event(warning_event), .ctl_rd_valid(ctl_rd_valid),
    .ctl_rd_data(8'h3c), .ctl_cmd(ctl_cmd), .ctl_wr_valid(ctl_wr_valid),
    .ctl_wr_data(ctl_wr_data), .ctl_wr_index(ctl_wr_index),
    .ctl_wr_end(ctl_wr_end), .ctl_rd_req(ctl_rd_req),
    .ctl_rd_index(ctl_rd_index), .wp_active(wp_active));
  psu_host_end i_psu_host_end (
    .clk(clk), .reset(reset), .link(i_psu_link_if.host),
    .op_valid(op_valid), .op_code(op_code), .op_wdata(op_wdata),
    .op_last(op_last), .op_ready(op_ready), .op_done(op_done),
    .op_rdata(op_rdata), .op_nack(op_nack), .alert_active(alert_active));
  psu_link_assertions #(.STRETCH_CYC(200), .TIMEOUT_CYC(1000))
    i_psu_link_assertions (
    .clk(clk), .reset(reset), .scl(i_psu_link_if.scl),
    .sda(i_psu_link_if.sda), .fault_alert_n(i_psu_link_if.fault_alert_n),
    .dev_scl_oe(i_psu_link_if.dev_scl_oe),
    .dev_sda_oe(i_psu_link_if.dev_sda_oe),
    .dev_alert_oe(i_psu_link_if.dev_alert_oe),
    .shutdown_event(shutdown_event), .warning_event(warning_event));

  // controller user side: answer reads late so the clock is stretched
  always @(posedge clk) begin
    ctl_rd_valid <= (rd_wait == 8'h01);
    if (ctl_rd_req === 1'b1) begin
      rd_wait <= 8'h28;
    end else if (rd_wait != 8'h00) begin
      rd_wait <= rd_wait - 8'h01;
    end
    if (ctl_wr_end === 1'b1) begin
      wr_end_seen <= 1'b1;
    end
    if (ctl_wr_valid === 1'b1) begin
      wr_pulses <= wr_pulses + 8'h01;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one host operation, returns at the edge where it completes
  task automatic do_op(input psu_link_pkg::host_op_e code,
                       input logic [7:0] b, input logic last);
    op_code <= code;
    op_wdata <= b;
    op_last <= last;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    do @(posedge clk); while (op_done !== 1'b1);
  endtask

  task automatic start;
    do_op(psu_link_pkg::OP_START, 8'h00, 1'b0);
  endtask

  task automatic stop;
    do_op(psu_link_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic put(input logic [7:0] b, input logic nack);
    do_op(psu_link_pkg::OP_WRITE, b, 1'b0);
    check(op_nack, nack);
  endtask

  // hang guard
  initial begin
    repeat (110000) @(posedge clk);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check(wp_active, 1'b1);
    check(op_ready, 1'b1);
    foreach (rows[i]) begin
      sel <= rows[i].sel;
      shutdown_event <= rows[i].sd;
      warning_event <= rows[i].wr;
      start();
      put(rows[i].addr, rows[i].nack);
      stop();
      check(alert_active, rows[i].sd | rows[i].wr);
      check(i_psu_link_if.fault_alert_n,
            !(rows[i].sd | rows[i].wr));
    end
    shutdown_event <= 1'b1;
    warning_event <= 1'b1;
    repeat (8) @(posedge clk);
    check(alert_active, 1'b1);
    shutdown_event <= 1'b0;
    warning_event <= 1'b0;
    repeat (8) @(posedge clk);
    check(alert_active, 1'b0);
    // clock held low past the limit: address afterwards is ignored
    start();
    repeat (1200) @(posedge clk);
    put(CTL, 1'b1);
    stop();
    // unprotect the memory through the controller
    start();
    put(CTL, 1'b0);
    put(8'h10, 1'b0);
    put(8'h00, 1'b0);
    stop();
    check(ctl_cmd, 8'h10);
    check(ctl_wr_index, 8'h00);
    check(ctl_wr_data, 8'h00);
    check(wr_end_seen, 1'b1);
    check(wr_pulses, 8'h01);
    check(wp_active, 1'b0);
    // single byte memory write, then read back with a repeated start
    // the host keeps to single byte accesses
    start();
    put(EEP, 1'b0);
    put(8'h00, 1'b0);
    put(8'h10, 1'b0);
    put(8'h5a, 1'b0);
    stop();
    start();
    put(EEP, 1'b0);
    put(8'h00, 1'b0);
    put(8'h10, 1'b0);
    start();
    put(EEP | 8'h01, 1'b0);
    do_op(psu_link_pkg::OP_READ, 8'h00, 1'b1);
    check(op_rdata, 8'h5a);
    stop();
    // controller read byte with a stretched clock
    start();
    put(CTL, 1'b0);
    put(8'h21, 1'b0);
    start();
    put(CTL | 8'h01, 1'b0);
    do_op(psu_link_pkg::OP_READ, 8'h00, 1'b1);
    check(op_rdata, 8'h3c);
    stop();
    check(ctl_cmd, 8'h21);
    check(ctl_rd_index, 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
